// file: rtl/sbs_status_bank.sv
// Purpose: core status register, bank selection and bank-3 register map on AHB-Lite
// Assumes: single word transfers only; mem_rdata valid in the cycle mem_req is high
// Notes:   hresetn is the power-on reset; other_reset is any later reset cause
`timescale 1ns/100ps

// Functional notes
// - direct bank bits select bank 0..3 for direct data addressing.
// - indirect bank bit selects banks 2/3 or 0/1 for pointer accesses.
// - arithmetic result flags override written values when status is destination.
// - watchdog expiry and powerdown flags ignore every write.
// - bit clear/set, nibble swap, move-to-file leave flags as written.
// - expiry flag set by power-up, watchdog clear, sleep; cleared by time-out.
// - nibble overflow flag is carry out of bit 3.
// - in subtraction carry flags mean no borrow.
// - status register answers at the same offset in all four banks.
// - indirect window accesses data memory at pointer address, no register.
// - upper PC buffer holds five bits loaded into upper PC.
// - unimplemented bank-3 locations read as zero.
// - sleep clears powerdown flag and sets expiry flag.
module sbs_status_bank
	import sbs_pkg::*;
(
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic      [31:0]           hrdata,
	input  wire logic                  exe_valid,
	input  wire sbs_exe_kind_t         exe_kind,
	input  wire logic [7:0]            exe_a,
	input  wire logic [7:0]            exe_b,
	input  wire logic                  exe_to_status,
	output logic      [7:0]            exe_result,
	input  wire logic                  sleep_instr,
	input  wire logic                  watchdog_clear_instr,
	input  wire logic                  watchdog_timeout,
	input  wire logic                  other_reset,
	input  wire logic                  other_reset_wdt,
	input  wire logic [BANK_OFS_W-1:0] direct_offset,
	output logic      [DMEM_AW-1:0]    direct_addr,
	output logic      [DMEM_AW-1:0]    indirect_addr,
	output logic                       mem_req,
	output logic                       mem_we,
	output logic      [DMEM_AW-1:0]    mem_addr,
	output logic      [7:0]            mem_wdata,
	input  wire logic [7:0]            mem_rdata,
	output logic                       pc_load,
	output logic      [12:0]           pc_load_value,
	output logic      [7:0]            core_status,
	output logic                       irq
);
	logic [7:0]         stat;
	logic [7:0]         option_control;
	logic [7:0]         program_counter_low;
	logic [7:0]         indirect_pointer;
	logic [7:0]         port_b_direction;
	logic [7:0]         port_f_direction;
	logic [7:0]         port_g_direction;
	logic [PCBUF_W-1:0] upper_pc_buffer;
	logic [7:0]         interrupt_control;
	logic [IRQ_W-1:0]   irq_status;
	logic [IRQ_W-1:0]   irq_mask;
	logic               wr_pend;
	logic [IDX_W-1:0]   wr_idx;
	logic [IDX_W-1:0]   rd_idx;
	sbs_rd_state_t      rd_state;
	logic               accept;
	logic               bus_wr;
	logic               bus_wr_status;
	logic [8:0]         sum9;
	logic [4:0]         sum5;
	logic [7:0]         next_result;
	logic [7:0]         rd_value;
	logic [IRQ_W-1:0]   irq_events;
	logic               is_arith;
	logic               sets_zero;

	assign core_status = stat;
	assign accept      = hsel & htrans[1] & hready;
	assign bus_wr      = wr_pend;
	// status decodes on the low seven index bits so every bank reaches it
	assign bus_wr_status = bus_wr & (wr_idx[6:0] == STATUS_LOW7);

	// subtraction is a plus the two's complement of b
	always_comb begin
		if (exe_kind == EXE_SUB) begin
			sum9 = {1'b0, exe_a} + {1'b0, ~exe_b} + 9'h001;
			sum5 = {1'b0, exe_a[3:0]} + {1'b0, ~exe_b[3:0]} + 5'h01;
		end else begin
			sum9 = {1'b0, exe_a} + {1'b0, exe_b};
			sum5 = {1'b0, exe_a[3:0]} + {1'b0, exe_b[3:0]};
		end
		if (exe_kind == EXE_ADD || exe_kind == EXE_SUB)
			next_result = sum9[7:0];
		else
			next_result = exe_b;
	end

	assign is_arith  = exe_valid & (exe_kind == EXE_ADD || exe_kind == EXE_SUB);
	assign sets_zero = exe_valid & (exe_kind != EXE_MOVE);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			exe_result <= 8'h00;
		else if (exe_valid)
			exe_result <= next_result;
	end

	// status register; hardware flag updates are applied after software writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat <= STATUS_POR;
		end else if (other_reset) begin
			stat[ST_IRP:ST_RP0] <= 3'h0;
			if (other_reset_wdt)
				stat[ST_TO:ST_PD] <= TOPD_WDT_RST;
		end else begin
			if (bus_wr_status) begin
				stat[ST_IRP:ST_RP0] <= hwdata[ST_IRP:ST_RP0];
				stat[ST_Z:ST_C]     <= hwdata[ST_Z:ST_C];
			end
			if (exe_valid && exe_to_status) begin
				stat[ST_IRP:ST_RP0] <= next_result[ST_IRP:ST_RP0];
				if (exe_kind == EXE_MOVE)
					stat[ST_Z:ST_C] <= exe_b[ST_Z:ST_C];
			end
			// flag updates override any written value for these bits
			if (sets_zero)
				stat[ST_Z] <= (next_result == 8'h00);
			if (is_arith) begin
				stat[ST_DC] <= sum5[4];
				stat[ST_C]  <= sum9[8];
			end
			if (watchdog_timeout)
				stat[ST_TO] <= 1'b0;
			else if (sleep_instr)
				stat[ST_TO:ST_PD] <= TOPD_SLEEP;
			else if (watchdog_clear_instr)
				stat[ST_TO:ST_PD] <= TOPD_WATCHDOG_CLEAR_INSTR;
		end
	end

	// bank-3 plain registers; other resets restore the documented values
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			option_control      <= OPTION_RST;
			program_counter_low <= PCL_RST;
			indirect_pointer    <= POINTER_RST;
			port_b_direction    <= TRIS_RST;
			port_f_direction    <= TRIS_RST;
			port_g_direction    <= TRIS_RST;
			upper_pc_buffer     <= PCBUF_RST;
			interrupt_control   <= INTCTL_RST;
			irq_mask            <= IRQ_RST;
		end else if (other_reset) begin
			option_control      <= OPTION_RST;
			program_counter_low <= PCL_RST;
			port_b_direction    <= TRIS_RST;
			port_f_direction    <= TRIS_RST;
			port_g_direction    <= TRIS_RST;
			upper_pc_buffer     <= PCBUF_RST;
			interrupt_control   <= {INTCTL_RST[7:1], interrupt_control[0]};
		end else if (bus_wr) begin
			case (wr_idx)
				IDX_OPTION:   option_control      <= hwdata[7:0];
				IDX_PCL:      program_counter_low <= hwdata[7:0];
				IDX_POINTER:  indirect_pointer    <= hwdata[7:0];
				IDX_PORT_B_DIRECTION:    port_b_direction    <= hwdata[7:0];
				IDX_PORT_F_DIRECTION:    port_f_direction    <= hwdata[7:0];
				IDX_PORT_G_DIRECTION:    port_g_direction    <= hwdata[7:0];
				IDX_PCBUF:    upper_pc_buffer     <= hwdata[PCBUF_W-1:0];
				IDX_INTCTL:   interrupt_control   <= hwdata[7:0];
				IDX_IRQ_MASK: irq_mask            <= hwdata[IRQ_W-1:0];
				default:      ;
			endcase
		end
	end

	// a low-byte write of the PC carries the buffered upper bits with it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_load       <= 1'b0;
			pc_load_value <= 13'h0000;
		end else begin
			pc_load <= bus_wr & (wr_idx == IDX_PCL) & ~other_reset;
			if (bus_wr && wr_idx == IDX_PCL)
				pc_load_value <= {upper_pc_buffer, hwdata[7:0]};
		end
	end

	// data memory addressing, one cycle behind the bank bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			direct_addr   <= '0;
			indirect_addr <= '0;
		end else begin
			direct_addr   <= {stat[ST_RP1:ST_RP0], direct_offset};
			indirect_addr <= {stat[ST_IRP], indirect_pointer};
		end
	end

	// sticky events; a set in the clearing cycle survives the clear
	assign irq_events = {other_reset, sleep_instr, watchdog_timeout};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status <= IRQ_RST;
		end else if (bus_wr && wr_idx == IDX_IRQ_STATUS) begin
			irq_status <= (irq_status & ~hwdata[IRQ_W-1:0]) | irq_events;
		end else begin
			irq_status <= irq_status | irq_events;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq <= 1'b0;
		else
			irq <= |(irq_status & irq_mask);
	end

	// read mux; the window returns data memory, unlisted indices read zero
	always_comb begin
		rd_value = 8'h00;
		if (rd_idx[6:0] == STATUS_LOW7) begin
			rd_value = stat;
		end else begin
			case (rd_idx)
				IDX_WINDOW:     rd_value = mem_rdata;
				IDX_OPTION:     rd_value = option_control;
				IDX_PCL:        rd_value = program_counter_low;
				IDX_POINTER:    rd_value = indirect_pointer;
				IDX_PORT_B_DIRECTION:      rd_value = port_b_direction;
				IDX_PORT_F_DIRECTION:      rd_value = port_f_direction;
				IDX_PORT_G_DIRECTION:      rd_value = port_g_direction;
				IDX_PCBUF:      rd_value = {3'h0, upper_pc_buffer};
				IDX_INTCTL:     rd_value = interrupt_control;
				IDX_IRQ_STATUS: rd_value = {5'h00, irq_status};
				IDX_IRQ_MASK:   rd_value = {5'h00, irq_mask};
				default:        rd_value = 8'h00;
			endcase
		end
	end

	// every read takes two wait states so a write just before it has landed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend   <= 1'b0;
			wr_idx    <= '0;
			rd_idx    <= '0;
			rd_state  <= RD_IDLE;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
		end else begin
			wr_pend <= accept & hwrite;
			if (accept)
				wr_idx <= haddr[IDX_W+1:2];
			case (rd_state)
				RD_IDLE: begin
					if (accept && !hwrite) begin
						rd_idx    <= haddr[IDX_W+1:2];
						hreadyout <= 1'b0;
						rd_state  <= RD_ISSUE;
					end
				end
				RD_ISSUE: rd_state <= RD_WAIT;
				RD_WAIT: begin
					hrdata    <= {24'h000000, rd_value};
					hreadyout <= 1'b1;
					rd_state  <= RD_IDLE;
				end
				default: rd_state <= RD_IDLE;
			endcase
		end
	end

	// window accesses go to data memory at the pointer address
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_req   <= 1'b0;
			mem_we    <= 1'b0;
			mem_addr  <= '0;
			mem_wdata <= 8'h00;
		end else if (bus_wr && wr_idx == IDX_WINDOW) begin
			mem_req   <= 1'b1;
			mem_we    <= 1'b1;
			mem_addr  <= {stat[ST_IRP], indirect_pointer};
			mem_wdata <= hwdata[7:0];
		end else if (rd_state == RD_ISSUE && rd_idx == IDX_WINDOW) begin
			mem_req   <= 1'b1;
			mem_we    <= 1'b0;
			mem_addr  <= {stat[ST_IRP], indirect_pointer};
		end else begin
			mem_req <= 1'b0;
			mem_we  <= 1'b0;
		end
	end

	// checks
	logic quiet;
	assign quiet = ~other_reset & ~watchdog_timeout & ~sleep_instr & ~watchdog_clear_instr;

	sequence s_read_start;
		accept && !hwrite && rd_state == RD_IDLE;
	endsequence
	// hreadyout rises at the second edge after the request, so it is sampled high at the third
	sequence s_read_done;
		##3 hreadyout;
	endsequence

	property p_direct_bank;
		@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> direct_addr == {$past(stat[ST_RP1:ST_RP0]), $past(direct_offset)};
	endproperty
	a_direct_bank: assert property (p_direct_bank) else $error("direct address ignores bank bits");

	property p_indirect_bank;
		@(posedge hclk) disable iff (!hresetn)
		mem_req |-> mem_addr[DMEM_AW-1] == $past(stat[ST_IRP]) && mem_addr[7:0] == $past(indirect_pointer);
	endproperty
	a_indirect_bank: assert property (p_indirect_bank) else $error("window address wrong");

	property p_flags_override;
		@(posedge hclk) disable iff (!hresetn)
		(exe_valid && exe_to_status && exe_kind == EXE_ADD && !other_reset)
			|=> stat[ST_Z] == (exe_result == 8'h00) && stat[ST_C] == $past(sum9[8]);
	endproperty
	a_flags_override: assert property (p_flags_override) else $error("flags not from result");

	property p_readonly_flags;
		@(posedge hclk) disable iff (!hresetn)
		(bus_wr_status && quiet) |=> $stable(stat[ST_TO:ST_PD]);
	endproperty
	a_readonly_flags: assert property (p_readonly_flags) else $error("write reached expiry or powerdown");

	property p_move_exact;
		@(posedge hclk) disable iff (!hresetn)
		(exe_valid && exe_to_status && exe_kind == EXE_MOVE && quiet && !bus_wr_status)
			|=> stat[ST_Z:ST_C] == $past(exe_b[ST_Z:ST_C]) && stat[ST_IRP:ST_RP0] == $past(exe_b[ST_IRP:ST_RP0]);
	endproperty
	a_move_exact: assert property (p_move_exact) else $error("move to status altered");

	property p_other_reset;
		@(posedge hclk) disable iff (!hresetn)
		(other_reset && other_reset_wdt) |=> stat[ST_IRP:ST_RP0] == 3'h0 && stat[ST_TO:ST_PD] == TOPD_WDT_RST
			&& stat[ST_Z:ST_C] == $past(stat[ST_Z:ST_C]);
	endproperty
	a_other_reset: assert property (p_other_reset) else $error("other reset status wrong");

	property p_timeout;
		@(posedge hclk) disable iff (!hresetn)
		(watchdog_timeout && !other_reset) |=> !stat[ST_TO] ##1 (stat[ST_TO] || !(sleep_instr || watchdog_clear_instr));
	endproperty
	a_timeout: assert property (p_timeout) else $error("time-out did not clear expiry flag");

	property p_sleep;
		@(posedge hclk) disable iff (!hresetn)
		(sleep_instr && !watchdog_timeout && !other_reset) |=> stat[ST_TO] && !stat[ST_PD];
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep flags wrong");

	property p_nibble_sub;
		@(posedge hclk) disable iff (!hresetn)
		(exe_valid && exe_kind == EXE_SUB && !other_reset)
			|=> stat[ST_DC] == ($past(exe_a[3:0]) >= $past(exe_b[3:0])) && stat[ST_C] == ($past(exe_a) >= $past(exe_b));
	endproperty
	a_nibble_sub: assert property (p_nibble_sub) else $error("borrow polarity wrong");

	property p_pc_load;
		@(posedge hclk) disable iff (!hresetn)
		pc_load |-> pc_load_value[12:8] == upper_pc_buffer;
	endproperty
	a_pc_load: assert property (p_pc_load) else $error("upper PC not from buffer");

	property p_unimpl_zero;
		@(posedge hclk) disable iff (!hresetn)
		(s_read_start and (haddr[IDX_W+1:2] >= IDX_PCBUF + 9'h002 && haddr[IDX_W+1:2] < IDX_IRQ_STATUS))
			|-> s_read_done ##0 hrdata == 32'h0000_0000;
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented location nonzero");

	property p_status_mirror;
		@(posedge hclk) disable iff (!hresetn)
		(s_read_start and haddr[8:2] == STATUS_LOW7 && quiet && !exe_valid)
			|-> s_read_done ##0 hrdata[7:0] == stat;
	endproperty
	a_status_mirror: assert property (p_status_mirror) else $error("status mirror read wrong");
endmodule : sbs_status_bank

// file: pkg/sbs_pkg.sv
// Purpose: shared constants and types for the status and bank select block
// Assumes: register index = printed offset, byte address = index * 4
// Notes:   one package for the whole block
package sbs_pkg;
	localparam int unsigned IDX_W         = 9;
	localparam int unsigned DMEM_AW       = 9;
	localparam int unsigned BANK_OFS_W    = 7;
	localparam int unsigned PCBUF_W       = 5;
	localparam int unsigned IRQ_W         = 3;

	// register indices
	localparam logic [8:0] IDX_WINDOW     = 9'h180;
	localparam logic [8:0] IDX_OPTION     = 9'h181;
	localparam logic [8:0] IDX_PCL        = 9'h182;
	localparam logic [8:0] IDX_STATUS     = 9'h183;
	localparam logic [8:0] IDX_POINTER    = 9'h184;
	localparam logic [8:0] IDX_PORT_B_DIRECTION      = 9'h186;
	localparam logic [8:0] IDX_PORT_F_DIRECTION      = 9'h187;
	localparam logic [8:0] IDX_PORT_G_DIRECTION      = 9'h188;
	localparam logic [8:0] IDX_PCBUF      = 9'h18a;
	localparam logic [8:0] IDX_INTCTL     = 9'h18b;
	localparam logic [8:0] IDX_IRQ_STATUS = 9'h1a0;
	localparam logic [8:0] IDX_IRQ_MASK   = 9'h1a1;
	localparam logic [6:0] STATUS_LOW7    = 7'h03;

	// status bit positions
	localparam int unsigned ST_IRP = 7;
	localparam int unsigned ST_RP1 = 6;
	localparam int unsigned ST_RP0 = 5;
	localparam int unsigned ST_TO  = 4;
	localparam int unsigned ST_PD  = 3;
	localparam int unsigned ST_Z   = 2;
	localparam int unsigned ST_DC  = 1;
	localparam int unsigned ST_C   = 0;

	// reset values, and expiry/powerdown values loaded by sleep and watchdog clear
	localparam logic [7:0] STATUS_POR     = 8'h18;
	localparam logic [1:0] TOPD_WDT_RST   = 2'h1;
	localparam logic [1:0] TOPD_SLEEP     = 2'h2;
	localparam logic [1:0] TOPD_WATCHDOG_CLEAR_INSTR    = 2'h3;
	localparam logic [7:0] OPTION_RST     = 8'hff;
	localparam logic [7:0] TRIS_RST       = 8'hff;
	localparam logic [7:0] PCL_RST        = 8'h00;
	localparam logic [7:0] POINTER_RST    = 8'h00;
	localparam logic [4:0] PCBUF_RST      = 5'h00;
	localparam logic [7:0] INTCTL_RST     = 8'h00;
	localparam logic [2:0] IRQ_RST        = 3'h0;

	// interrupt status bits
	localparam int unsigned IRQ_WDT   = 0;
	localparam int unsigned IRQ_SLEEP = 1;
	localparam int unsigned IRQ_RESET = 2;

	typedef enum logic [1:0] {
		EXE_ADD   = 2'h0,
		EXE_SUB   = 2'h1,
		EXE_LOGIC = 2'h2,
		EXE_MOVE  = 2'h3
	} sbs_exe_kind_t;

	typedef enum logic [1:0] {RD_IDLE, RD_ISSUE, RD_WAIT} sbs_rd_state_t;
endpackage : sbs_pkg

// file: tb/status_and_bank_select_test.sv
// Purpose: self-checking bench for the status register, bank select and bank-3 register map
// Assumes: AHB-Lite single word transfers; byte address is four times the register index
// Notes:   memory side answers window reads with a fixed byte, another value off request
`timescale 1ns/100ps
module status_and_bank_select_test
	import sbs_pkg::*;
();
	logic          hclk;
	logic          hresetn;
	logic          hsel;
	logic [31:0]   haddr;
	logic [1:0]    htrans;
	logic          hwrite;
	logic [2:0]    hsize;
	logic [31:0]   hwdata;
	wire logic     hready;
	logic          hreadyout;
	logic          hresp;
	logic [31:0]   hrdata;
	logic          exe_valid;
	sbs_exe_kind_t exe_kind;
	logic [7:0]    exe_a;
	logic [7:0]    exe_b;
	logic          exe_to_status;
	logic [7:0]    exe_result;
	logic          sleep_instr;
	logic          watchdog_clear_instr;
	logic          watchdog_timeout;
	logic          other_reset;
	logic          other_reset_wdt;
	logic [6:0]    direct_offset;
	logic [8:0]    direct_addr;
	logic [8:0]    indirect_addr;
	logic          mem_req;
	logic          mem_we;
	logic [8:0]    mem_addr;
	logic [7:0]    mem_wdata;
	wire logic [7:0] mem_rdata;
	logic          pc_load;
	logic [12:0]   pc_load_value;
	logic [7:0]    core_status;
	logic          irq;
	int            fails;
	int            n_tests;
	int            m_cnt;
	int            p_cnt;
	logic          m_we;
	logic [8:0]    m_addr;
	logic [7:0]    m_wd;
	logic [12:0]   p_val;
	int            i;
	logic [8:0]    ridx [7] = '{IDX_OPTION, IDX_PCL, IDX_PORT_B_DIRECTION, IDX_PORT_F_DIRECTION, IDX_PORT_G_DIRECTION, IDX_PCBUF, IDX_INTCTL};
	logic [7:0]    rval [7] = '{8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00};
	logic [8:0]    uidx [6] = '{9'h185, 9'h189, 9'h18c, 9'h19f, 9'h005, 9'h1a5};

	assign hready = hreadyout;
	// off-request value differs so a late sample is caught
	assign mem_rdata = mem_req ? 8'h5c : 8'ha3;

	sbs_status_bank sbs_status_bank_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .exe_valid(exe_valid), .exe_kind(exe_kind), .exe_a(exe_a), .exe_b(exe_b),
		.exe_to_status(exe_to_status), .exe_result(exe_result), .sleep_instr(sleep_instr),
		.watchdog_clear_instr(watchdog_clear_instr), .watchdog_timeout(watchdog_timeout),
		.other_reset(other_reset), .other_reset_wdt(other_reset_wdt), .direct_offset(direct_offset),
		.direct_addr(direct_addr), .indirect_addr(indirect_addr), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .pc_load(pc_load),
		.pc_load_value(pc_load_value), .core_status(core_status), .irq(irq)
	);

	always #12.5 hclk = ~hclk;

	always @(posedge hclk) begin
		if (mem_req === 1'b1) begin
			m_cnt <= m_cnt + 1;
			m_we <= mem_we;
			m_addr <= mem_addr;
			m_wd <= mem_wdata;
		end
		if (pc_load === 1'b1) begin
			p_cnt <= p_cnt + 1;
			p_val <= pc_load_value;
		end
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic stc(input logic [7:0] exp);
		chk("core_status", {24'h0, core_status}, {24'h0, exp});
	endtask : stc

	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50)
			fails++;
	endtask : wait_ready

	task automatic bus(input logic wr_n, input logic [8:0] idx, input logic [7:0] wd, output logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {21'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr_n;
		wait_ready();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= {24'h0, wd};
		wait_ready();
		d = hrdata;
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask : bus

	task automatic wr(input logic [8:0] idx, input logic [7:0] wd);
		logic [31:0] d;
		bus(1'b1, idx, wd, d);
	endtask : wr

	task automatic rdc(input string name, input logic [8:0] idx, input logic [7:0] exp);
		logic [31:0] d;
		bus(1'b0, idx, 8'h00, d);
		chk(name, d, {24'h0, exp});
	endtask : rdc

	task automatic exe(input sbs_exe_kind_t k, input logic [7:0] a, input logic [7:0] b, input logic ts,
		input logic [7:0] res, input logic [7:0] st);
		exe_valid <= 1'b1;
		exe_kind <= k;
		exe_a <= a;
		exe_b <= b;
		exe_to_status <= ts;
		@(posedge hclk);
		exe_valid <= 1'b0;
		exe_to_status <= 1'b0;
		@(posedge hclk);
		chk("exe_result", {24'h0, exe_result}, {24'h0, res});
		stc(st);
	endtask : exe

	// 0 sleep, 1 watchdog clear, 2 time-out, 3 other reset
	task automatic evt(input int k, input logic [7:0] st);
		case (k)
			0: sleep_instr <= 1'b1;
			1: watchdog_clear_instr <= 1'b1;
			2: watchdog_timeout <= 1'b1;
			default: other_reset <= 1'b1;
		endcase
		@(posedge hclk);
		sleep_instr <= 1'b0;
		watchdog_clear_instr <= 1'b0;
		watchdog_timeout <= 1'b0;
		other_reset <= 1'b0;
		@(posedge hclk);
		stc(st);
	endtask : evt

	task automatic irq_is(input logic exp);
		repeat (2) @(posedge hclk);
		chk("irq", {31'h0, irq}, {31'h0, exp});
	endtask : irq_is

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up

	initial begin
		repeat (5000) @(posedge hclk);
		fails++;
		wrap_up();
	end

	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		exe_valid = 1'b0;
		exe_kind = EXE_ADD;
		exe_a = 8'h00;
		exe_b = 8'h00;
		exe_to_status = 1'b0;
		sleep_instr = 1'b0;
		watchdog_clear_instr = 1'b0;
		watchdog_timeout = 1'b0;
		other_reset = 1'b0;
		other_reset_wdt = 1'b0;
		direct_offset = 7'h55;
		fails = 0;
		n_tests = 0;
		m_cnt = 0;
		p_cnt = 0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		stc(8'h18);
		for (i = 0; i < 7; i++) rdc("reset value", ridx[i], rval[i]);
		wr(IDX_POINTER, 8'h3c);
		rdc("pointer", IDX_POINTER, 8'h3c);
		for (i = 0; i < 8; i++) begin
			wr(IDX_STATUS, {i[2:0], 5'h00});
			repeat (2) @(posedge hclk);
			chk("direct_addr", {23'h0, direct_addr}, {23'h0, i[1:0], 7'h55});
			chk("indirect_addr", {23'h0, indirect_addr}, {23'h0, i[2], 8'h3c});
			rdc("status", IDX_STATUS, {i[2:0], 5'h18});
		end
		wr(IDX_WINDOW, 8'h77);
		repeat (2) @(posedge hclk);
		chk("window write", {m_cnt[7:0], 3'h0, m_we, 3'h0, m_addr, m_wd}, {8'h01, 3'h0, 1'b1, 3'h0, 9'h13c, 8'h77});
		rdc("window read", IDX_WINDOW, 8'h5c);
		@(posedge hclk);
		chk("window req", {m_cnt[7:0], 3'h0, m_we, 3'h0, m_addr}, {8'h02, 3'h0, 1'b0, 3'h0, 9'h13c});
		wr(9'h003, 8'h05);
		for (i = 0; i < 4; i++) rdc("status mirror", {i[1:0], STATUS_LOW7}, 8'h1d);
		wr(IDX_PCBUF, 8'hff);
		rdc("pc buffer", IDX_PCBUF, 8'h1f);
		wr(IDX_PCL, 8'h34);
		repeat (2) @(posedge hclk);
		chk("pc load", {p_cnt[15:0], 3'h0, p_val}, {16'h1, 3'h0, 5'h1f, 8'h34});
		wr(IDX_PORT_F_DIRECTION, 8'h5a);
		rdc("port_f_direction", IDX_PORT_F_DIRECTION, 8'h5a);
		for (i = 0; i < 6; i++) begin
			wr(uidx[i], 8'hff);
			rdc("unimplemented", uidx[i], 8'h00);
		end
		exe(EXE_ADD, 8'h0f, 8'h01, 1'b0, 8'h10, 8'h1a);
		exe(EXE_ADD, 8'hff, 8'h01, 1'b0, 8'h00, 8'h1f);
		exe(EXE_SUB, 8'h05, 8'h03, 1'b0, 8'h02, 8'h1b);
		exe(EXE_SUB, 8'h03, 8'h05, 1'b0, 8'hfe, 8'h18);
		exe(EXE_LOGIC, 8'h00, 8'h00, 1'b0, 8'h00, 8'h1c);
		exe(EXE_MOVE, 8'h00, 8'h07, 1'b0, 8'h07, 8'h1c);
		wr(IDX_STATUS, 8'he0);
		rdc("status", IDX_STATUS, 8'hf8);
		exe(EXE_LOGIC, 8'h00, 8'h00, 1'b1, 8'h00, 8'h1c);
		exe(EXE_ADD, 8'hf0, 8'h30, 1'b1, 8'h20, 8'h39);
		exe(EXE_MOVE, 8'h00, 8'h47, 1'b1, 8'h47, 8'h5f);
		evt(0, 8'h57);
		evt(2, 8'h47);
		evt(3, 8'h07);
		evt(1, 8'h1f);
		wr(IDX_STATUS, 8'ha0);
		other_reset_wdt <= 1'b1;
		evt(3, 8'h08);
		other_reset_wdt <= 1'b0;
		rdc("port_f_direction", IDX_PORT_F_DIRECTION, 8'hff);
		rdc("pc buffer", IDX_PCBUF, 8'h00);
		rdc("pointer", IDX_POINTER, 8'h3c);
		rdc("irq status", IDX_IRQ_STATUS, 8'h07);
		irq_is(1'b0);
		wr(IDX_IRQ_MASK, 8'h02);
		irq_is(1'b1);
		wr(IDX_IRQ_STATUS, 8'h02);
		irq_is(1'b0);
		rdc("irq status", IDX_IRQ_STATUS, 8'h05);
		wr(IDX_IRQ_MASK, 8'h05);
		rdc("irq mask", IDX_IRQ_MASK, 8'h05);
		irq_is(1'b1);
		wr(IDX_IRQ_STATUS, 8'h05);
		irq_is(1'b0);
		wrap_up();
	end
endmodule : status_and_bank_select_test
